// [jtbs_tap.sv]
// Device end: TAP controller, instruction and data registers, pad muxing
`timescale 1ns/1ps
module jtbs_tap (
  // System clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Test link
  jtbs_link_if.dev link,
  // Core side of the pins
  input wire logic [jtbs_pkg::NPINS-1:0] core_pud_i,
  input wire logic [jtbs_pkg::NPINS-1:0] core_oe_i,
  input wire logic [jtbs_pkg::NPINS-1:0] core_out_i,
  input wire logic core_ana_ctl_i,
  // Pad side of the pins
  input wire logic [jtbs_pkg::NPINS-1:0] pad_in_i,
  input wire logic ana_in_i,
  output logic [jtbs_pkg::NPINS-1:0] pad_pu_o,
  output logic [jtbs_pkg::NPINS-1:0] pad_oe_o,
  output logic [jtbs_pkg::NPINS-1:0] pad_out_o,
  output logic ana_ctl_o,
  // Status
  output logic device_reset_o,
  output logic [jtbs_pkg::IR_W-1:0] instr_o
);
  import jtbs_pkg::*;

  //----------------------------------------------------------------------
  // Crossings into the TCK domain
  //----------------------------------------------------------------------
  logic por_s1_r, por_s2_r;
  logic [BS_LEN-1:0] cap_s1_r, cap_s2_r;
  logic [BS_LEN-1:0] cap_raw;
  logic tap_rst;

  // Gather what Capture-DR sees: core drive, pad levels, analog side
  for (genvar p = 0; p < NPINS; p++) begin : g_cap
    assign cap_raw[p*CELLS_PER_PIN+CELL_PUD] = core_pud_i[p];
    assign cap_raw[p*CELLS_PER_PIN+CELL_OC] = core_oe_i[p];
    assign cap_raw[p*CELLS_PER_PIN+CELL_OD] = core_out_i[p];
    assign cap_raw[p*CELLS_PER_PIN+CELL_ID] = pad_in_i[p];
  end
  assign cap_raw[CELL_ANA_CTL] = core_ana_ctl_i;
  assign cap_raw[CELL_ANA_IN] = ana_in_i;

  // Reset takes hold at once, since the host stops tck while it is low;
  // its release still passes two tck flops
  always_ff @(posedge link.tck or negedge resetn_i) begin
    if (!resetn_i) begin
      por_s1_r <= 1'b0;
      por_s2_r <= 1'b0;
    end else begin
      por_s1_r <= 1'b1;
      por_s2_r <= por_s1_r;
    end
  end

  // Pins pass two flops before use
  always_ff @(posedge link.tck) begin
    cap_s1_r <= cap_raw;
    cap_s2_r <= cap_s1_r;
  end
  assign tap_rst = ~por_s2_r;

  //----------------------------------------------------------------------
  // TAP state machine
  //----------------------------------------------------------------------
  jtbs_state_t st_r, st_nxt;
  logic tms;
  assign tms = link.tms;

  // Every move is decided by TMS at the rising edge
  always_comb begin
    unique case (st_r)
      ST_TLR: st_nxt = tms ? ST_TLR : ST_RTI;
      ST_RTI: st_nxt = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: st_nxt = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: st_nxt = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: st_nxt = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: st_nxt = tms ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR: st_nxt = tms ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: st_nxt = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: st_nxt = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: st_nxt = tms ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: st_nxt = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: st_nxt = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: st_nxt = tms ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR: st_nxt = tms ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: st_nxt = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: st_nxt = tms ? ST_SEL_DR : ST_RTI;
    endcase
  end

  // Power-on reset parks the controller in Test-Logic-Reset
  always_ff @(posedge link.tck or negedge por_s2_r) begin
    if (!por_s2_r) begin
      st_r <= ST_TLR;
    end else begin
      st_r <= st_nxt;
    end
  end

  //----------------------------------------------------------------------
  // Instruction register
  //----------------------------------------------------------------------
  logic [IR_W-1:0] ir_sr_r, ir_r;

  // Shift in at the top so the first bit ends up as the LSB
  always_ff @(posedge link.tck) begin
    if (tap_rst || st_r == ST_TLR) begin
      ir_sr_r <= IR_CAPTURE;
      ir_r <= IR_RESET;
    end else begin
      unique case (st_r)
        ST_CAP_IR: ir_sr_r <= IR_CAPTURE;
        ST_SH_IR: ir_sr_r <= {link.tdi, ir_sr_r[IR_W-1:1]};
        ST_UPD_IR: ir_r <= ir_sr_r;
        default: ;
      endcase
    end
  end
  assign instr_o = ir_r;

  //----------------------------------------------------------------------
  // Instruction decode
  //----------------------------------------------------------------------
  wire sel_extest = (ir_r == OP_EXTEST);
  wire sel_sample = (ir_r == OP_SAMPLE);
  wire sel_bs = sel_extest | sel_sample;
  wire sel_id = (ir_r == OP_IDCODE);
  wire sel_rst = (ir_r == OP_DEVRST);
  wire sel_byp = ~(sel_bs | sel_id | sel_rst);
  wire [ID_W-1:0] id_value = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

  //----------------------------------------------------------------------
  // Data registers
  //----------------------------------------------------------------------
  logic [BS_LEN-1:0] bs_sr_r, bs_upd_r;
  logic [ID_W-1:0] id_sr_r;
  logic rst_sr_r, byp_r;

  // Boundary chain: capture pins, shift toward TDO, update latches
  always_ff @(posedge link.tck) begin
    if (tap_rst) begin
      bs_sr_r <= '0;
      bs_upd_r <= '0;
    end else if (sel_bs) begin
      unique case (st_r)
        ST_CAP_DR: bs_sr_r <= cap_s2_r;
        ST_SH_DR: bs_sr_r <= {link.tdi, bs_sr_r[BS_LEN-1:1]};
        ST_UPD_DR: bs_upd_r <= bs_sr_r;
        default: ;
      endcase
    end
  end

  // Identification register loads its fixed value on capture
  always_ff @(posedge link.tck) begin
    if (tap_rst) begin
      id_sr_r <= '0;
    end else if (sel_id && st_r == ST_CAP_DR) begin
      id_sr_r <= id_value;
    end else if (sel_id && st_r == ST_SH_DR) begin
      id_sr_r <= {link.tdi, id_sr_r[ID_W-1:1]};
    end
  end

  // Reset bit acts unlatched; leaving the TAP running is the point
  always_ff @(posedge link.tck) begin
    if (tap_rst) begin
      rst_sr_r <= 1'b0;
      byp_r <= 1'b0;
    end else if (st_r == ST_SH_DR) begin
      if (sel_rst) begin
        rst_sr_r <= link.tdi;
      end
      byp_r <= link.tdi;
    end else if (st_r == ST_CAP_DR) begin
      byp_r <= 1'b0;
    end
  end

  //----------------------------------------------------------------------
  // TDO, launched on the falling edge
  //----------------------------------------------------------------------
  logic tdo_r, tdo_oe_r;
  wire sh_ir = (st_r == ST_SH_IR);
  wire sh_dr = (st_r == ST_SH_DR);
  wire dr_bit = sel_bs ? bs_sr_r[0] : sel_id ? id_sr_r[0] :
                sel_rst ? rst_sr_r : byp_r;
  wire tdo_sel = sh_ir ? ir_sr_r[0] : dr_bit;

  // Falling-edge launch gives the host a full half period of setup
  always_ff @(negedge link.tck or negedge por_s2_r) begin
    if (!por_s2_r) begin
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else begin
      tdo_r <= tdo_sel;
      tdo_oe_r <= sh_ir | sh_dr;
    end
  end
  assign link.tdo = tdo_r;
  assign link.tdo_oe = tdo_oe_r;

  //----------------------------------------------------------------------
  // Device reset back into the system clock domain
  //----------------------------------------------------------------------
  logic drst_s1_r, drst_s2_r;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      drst_s1_r <= 1'b0;
      drst_s2_r <= 1'b0;
    end else begin
      drst_s1_r <= rst_sr_r;
      drst_s2_r <= drst_s1_r;
    end
  end
  assign device_reset_o = drst_s2_r;

  //----------------------------------------------------------------------
  // Pad muxing
  //----------------------------------------------------------------------
  // EXTEST hands the pads to the update latches at once; device reset
  // floats them since every pin leaves reset tri-stated
  for (genvar p = 0; p < NPINS; p++) begin : g_pad
    wire b_pud = bs_upd_r[p*CELLS_PER_PIN+CELL_PUD];
    wire b_oc = bs_upd_r[p*CELLS_PER_PIN+CELL_OC];
    wire b_od = bs_upd_r[p*CELLS_PER_PIN+CELL_OD];
    wire c_oe = core_oe_i[p] & ~drst_s2_r;
    wire c_pu = ~core_pud_i[p] & ~drst_s2_r;
    assign pad_oe_o[p] = sel_extest ? b_oc : c_oe;
    assign pad_out_o[p] = sel_extest ? b_od : core_out_i[p];
    assign pad_pu_o[p] = sel_extest ? ~b_pud : c_pu;
  end
  assign ana_ctl_o = sel_extest ? bs_upd_r[CELL_ANA_CTL] : core_ana_ctl_i;

endmodule : jtbs_tap

// [jtbs_pkg.sv]
// Shared constants and types of the test access port and its host
//------------------------------------------------------------------------
// Overview of operation
// - Sixteen-state TAP controller governs all test access
// - TMS at each rising TCK decides transitions
// - Power-on reset starts controller in Test-Logic-Reset
// - All shift registers move LSB first
// - Host reaches Shift-IR with TMS 1,1,0,0
// - Host holds TMS low, raises it on top bit
// - Captured instruction value 0x01 shifts out on TDO
// - Instruction selects data register and its logic
// - TMS 1,1,0 back to idle; Update-IR loads
// - Instruction register is four bits wide
// - Device-reset instruction floats all pins, no HIGHZ
// - Code 0x0 selects boundary-scan chain (EXTEST)
// - EXTEST drives latched chain values onto pins
// - EXTEST Capture-DR samples the external pins
// - EXTEST Shift-DR moves chain one place per TCK
// - EXTEST Update-DR applies chain to output pins
// - Chain holds pull-up, control, data, input per pin
// - Chain includes digital-analog boundary
// - Code 0x1 selects 32-bit identification register
// - IDCODE is the instruction after power-up
// - IDCODE capture loads ID, shift moves it out
// - Code 0x2 samples pins, preloads latches, unconnected
// - Code 0xC selects reset bit; TAP not reset
//------------------------------------------------------------------------
package jtbs_pkg;

  //----------------------------------------------------------------------
  // Controller states
  //----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_TLR    = 4'h0,
    ST_RTI    = 4'h1,
    ST_SEL_DR = 4'h2,
    ST_CAP_DR = 4'h3,
    ST_SH_DR  = 4'h4,
    ST_EX1_DR = 4'h5,
    ST_PA_DR  = 4'h6,
    ST_EX2_DR = 4'h7,
    ST_UPD_DR = 4'h8,
    ST_SEL_IR = 4'h9,
    ST_CAP_IR = 4'hA,
    ST_SH_IR  = 4'hB,
    ST_EX1_IR = 4'hC,
    ST_PA_IR  = 4'hD,
    ST_EX2_IR = 4'hE,
    ST_UPD_IR = 4'hF
  } jtbs_state_t;

  //----------------------------------------------------------------------
  // Instruction register
  //----------------------------------------------------------------------
  localparam int IR_W = 4;
  localparam logic [IR_W-1:0] OP_EXTEST = 4'h0;
  localparam logic [IR_W-1:0] OP_IDCODE = 4'h1;
  localparam logic [IR_W-1:0] OP_SAMPLE = 4'h2;
  localparam logic [IR_W-1:0] OP_DEVRST = 4'hC;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_W-1:0] IR_RESET = OP_IDCODE;

  //----------------------------------------------------------------------
  // Identification register (field values are arbitrary)
  //----------------------------------------------------------------------
  localparam int ID_W = 32;
  localparam logic [3:0] ID_VERSION = 4'h1;
  localparam logic [15:0] ID_PART = 16'h0001;
  localparam logic [10:0] ID_MAKER = 11'h001;

  //----------------------------------------------------------------------
  // Boundary-scan chain layout
  //----------------------------------------------------------------------
  localparam int NPINS = 4;
  localparam int CELLS_PER_PIN = 4;
  localparam int CELL_PUD = 0;
  localparam int CELL_OC = 1;
  localparam int CELL_OD = 2;
  localparam int CELL_ID = 3;
  localparam int CELL_ANA_CTL = NPINS * CELLS_PER_PIN;
  localparam int CELL_ANA_IN = CELL_ANA_CTL + 1;
  localparam int BS_LEN = CELL_ANA_IN + 1;

  //----------------------------------------------------------------------
  // Host timing and TMS preambles (LSB presented first)
  //----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int TCK_PERIOD_NS = 48;
  localparam int TCK_HALF = TCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [3:0] TCK_HALF_M1 = 4'(TCK_HALF - 1);
  localparam logic [2:0] TLR_ONES = 3'h5;
  localparam logic [3:0] PRE_IR = 4'h3;
  localparam logic [2:0] PRE_IR_LEN = 3'h4;
  localparam logic [3:0] PRE_DR = 4'h1;
  localparam logic [2:0] PRE_DR_LEN = 3'h3;
  localparam logic [5:0] LEN_MAX = 6'h20;

  //----------------------------------------------------------------------
  // Host sequencer phases
  //----------------------------------------------------------------------
  typedef enum logic [2:0] {
    HP_RST  = 3'h0,
    HP_GO   = 3'h1,
    HP_IDLE = 3'h2,
    HP_PRE  = 3'h3,
    HP_SH   = 3'h4,
    HP_UPD  = 3'h5,
    HP_RET  = 3'h6
  } jtbs_phase_t;

endpackage : jtbs_pkg

// [jtbs_link_if.sv]
// Test link between the host end and the device end
`timescale 1ns/1ps
interface jtbs_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;
  logic tdo_line;

  // Undriven TDO reads high, as with a pull-up on the line
  assign tdo_line = tdo_oe ? tdo : 1'b1;

  modport dev (
    input tck,
    input tms,
    input tdi,
    output tdo,
    output tdo_oe
  );

  modport host (
    output tck,
    output tms,
    output tdi,
    input tdo_line
  );
endinterface : jtbs_link_if

// [jtbs_host.sv]
// Host end: TCK divider and TMS/TDI sequencer for one scan at a time
`timescale 1ns/1ps
module jtbs_host (
  // System clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Test link
  jtbs_link_if.host link,
  // Scan request
  input wire logic start_i,
  input wire logic is_ir_i,
  input wire logic [5:0] len_i,
  input wire logic [31:0] wdata_i,
  // Scan result
  output logic busy_o,
  output logic done_o,
  output logic [31:0] rdata_o
);
  import jtbs_pkg::*;

  //----------------------------------------------------------------------
  // TCK divider
  //----------------------------------------------------------------------
  logic [3:0] div_r;
  logic tck_r;
  wire wrap = (div_r == TCK_HALF_M1);
  wire rise_ev = wrap & ~tck_r;
  wire fall_ev = wrap & tck_r;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      div_r <= '0;
      tck_r <= 1'b0;
    end else begin
      div_r <= wrap ? 4'h0 : div_r + 4'h1;
      tck_r <= tck_r ^ wrap;
    end
  end

  //----------------------------------------------------------------------
  // TDO synchroniser
  //----------------------------------------------------------------------
  logic tdo_s1_r, tdo_s2_r;

  always_ff @(posedge clk_i) begin
    tdo_s1_r <= link.tdo_line;
    tdo_s2_r <= tdo_s1_r;
  end

  //----------------------------------------------------------------------
  // Sequencer
  //----------------------------------------------------------------------
  jtbs_phase_t ph_r;
  logic pend_r, ir_r, tms_r, tdi_r, done_r;
  logic [5:0] len_r, cnt_r;
  logic [3:0] pre_r;
  logic [31:0] dat_r, cap_r, rd_r;

  wire go = (ph_r == HP_IDLE) & pend_r & fall_ev;
  wire last = (cnt_r == len_r - 6'h1);
  wire [5:0] pad_sh = LEN_MAX - len_r;
  wire [3:0] pre_ld = ir_r ? PRE_IR : PRE_DR;
  wire [2:0] pre_len = ir_r ? PRE_IR_LEN : PRE_DR_LEN;

  // TMS each phase presents; the last shift bit raises it to leave
  wire tms_now = (ph_r == HP_RST) | (ph_r == HP_UPD) |
                 (ph_r == HP_PRE & pre_r[0]) |
                 (ph_r == HP_SH & last);

  // Drive TMS and TDI at the falling edge, steady at the rising one
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      tms_r <= 1'b1;
      tdi_r <= 1'b0;
    end else if (go) begin
      tms_r <= pre_ld[0];
      tdi_r <= 1'b0;
    end else if (fall_ev) begin
      tms_r <= tms_now;
      tdi_r <= dat_r[0];
    end
  end

  // A request is taken only while none is pending; phases advance at the rising edge, except idle to preamble at the falling one
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ph_r <= HP_RST;
      pend_r <= 1'b0;
      ir_r <= 1'b0;
      len_r <= 6'h1;
      cnt_r <= '0;
      pre_r <= '0;
      dat_r <= '0;
      cap_r <= '0;
      rd_r <= '0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start_i && !pend_r) begin
        pend_r <= 1'b1;
        ir_r <= is_ir_i;
        len_r <= (len_i == 6'h0) ? 6'h1 : len_i;
        dat_r <= wdata_i;
      end
      if (go) begin
        ph_r <= HP_PRE;
        pre_r <= pre_ld;
        cnt_r <= 6'(pre_len);
      end else if (rise_ev) begin
        unique case (ph_r)
          HP_RST: begin
            cnt_r <= cnt_r + 6'h1;
            if (cnt_r == 6'(TLR_ONES - 3'h1)) begin
              ph_r <= HP_GO;
            end
          end
          HP_GO: ph_r <= HP_IDLE;
          HP_IDLE: ;
          HP_PRE: begin
            pre_r <= {1'b0, pre_r[3:1]};
            cnt_r <= cnt_r - 6'h1;
            if (cnt_r == 6'h1) begin
              ph_r <= HP_SH;
            end
          end
          HP_SH: begin
            cap_r <= {tdo_s2_r, cap_r[31:1]};
            dat_r <= {1'b0, dat_r[31:1]};
            cnt_r <= cnt_r + 6'h1;
            if (last) begin
              ph_r <= HP_UPD;
            end
          end
          HP_UPD: ph_r <= HP_RET;
          HP_RET: begin
            ph_r <= HP_IDLE;
            pend_r <= 1'b0;
            done_r <= 1'b1;
            rd_r <= cap_r >> pad_sh;
          end
          default: ph_r <= HP_RST;
        endcase
        if (ph_r == HP_PRE && cnt_r == 6'h1) begin
          cnt_r <= '0;
        end
      end
    end
  end

  //----------------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------------
  assign link.tck = tck_r;
  assign link.tms = tms_r;
  assign link.tdi = tdi_r;
  assign busy_o = pend_r | (ph_r != HP_IDLE);
  assign done_o = done_r;
  assign rdata_o = rd_r;

endmodule : jtbs_host

// [jtbs_link_chk.sv]
// Checker of the test link: controller states, shifts and instruction flow
`timescale 1ns/1ps
module jtbs_link_chk (
  // Link
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic tdo_line,
  // Reset and status
  input wire logic resetn_i,
  input wire logic [jtbs_pkg::IR_W-1:0] instr_o
);
  import jtbs_pkg::*;
  jtbs_state_t st_r;
  jtbs_state_t st_nxt;
  logic [IR_W-1:0] ir_r;
  logic [ID_W-1:0] dr_r;
  logic id_r;
  logic shift_st;
  logic byp_op;

  // ------------------------------------------------------------------
  // Reference controller
  // ------------------------------------------------------------------
  // Codes without a register of their own fall back to the bypass bit
  assign shift_st = st_r inside {ST_SH_IR, ST_SH_DR};
  assign byp_op = !(instr_o inside {OP_EXTEST, OP_IDCODE, OP_SAMPLE,
                                    OP_DEVRST});

  // Next state from tms, both update states behave alike
  always_comb begin
    case (st_r)
      ST_TLR: st_nxt = tms ? ST_TLR : ST_RTI;
      ST_RTI: st_nxt = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: st_nxt = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: st_nxt = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: st_nxt = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: st_nxt = tms ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR: st_nxt = tms ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: st_nxt = tms ? ST_UPD_DR : ST_SH_DR;
      ST_SEL_IR: st_nxt = tms ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: st_nxt = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: st_nxt = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: st_nxt = tms ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR: st_nxt = tms ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: st_nxt = tms ? ST_UPD_IR : ST_SH_IR;
      default: st_nxt = tms ? ST_SEL_DR : ST_RTI;
    endcase
  end

  // Async clear, since tck may stand still while reset is low
  always_ff @(posedge tck or negedge resetn_i) begin
    if (!resetn_i) st_r <= ST_TLR;
    else st_r <= st_nxt;
  end

  // Instruction shifter, captured pattern then tdi from the top
  always_ff @(posedge tck) begin
    if (st_r == ST_CAP_IR) ir_r <= IR_CAPTURE;
    else if (st_r == ST_SH_IR) ir_r <= {tdi, ir_r[IR_W-1:1]};
  end

  // Identification shifter, valid only when captured under IDCODE
  always_ff @(posedge tck) begin
    if (st_r == ST_CAP_DR) id_r <= (instr_o == OP_IDCODE);
    if (st_r == ST_CAP_DR) dr_r <= {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
    else if (st_r == ST_SH_DR) dr_r <= {tdi, dr_r[ID_W-1:1]};
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_oe_in_shift: assert property (
    @(posedge tck) disable iff (!resetn_i) tdo_oe == shift_st)
    else $error("tdo enable outside a shift state");
  a_oe_from_cap: assert property (
    @(posedge tck) disable iff (!resetn_i) $rose(tdo_oe) |->
    $past(st_r) inside {ST_CAP_IR, ST_CAP_DR, ST_EX2_IR, ST_EX2_DR})
    else $error("tdo enable rose without a capture");
  a_ir_capture: assert property (
    @(posedge tck) disable iff (!resetn_i)
    st_r == ST_SH_IR |-> tdo == ir_r[0])
    else $error("instruction capture bit wrong on tdo");
  a_ir_update: assert property (
    @(posedge tck) disable iff (!resetn_i)
    $past(st_r) == ST_UPD_IR |-> instr_o == ir_r)
    else $error("instruction not updated from shifter");
  a_five_ones: assert property (
    @(posedge tck) disable iff (!resetn_i)
    tms [*5] |=> ##1 instr_o == OP_IDCODE)
    else $error("five high tms did not restore IDCODE");
  a_id_shift: assert property (
    @(posedge tck) disable iff (!resetn_i)
    st_r == ST_SH_DR && id_r |-> tdo == dr_r[0])
    else $error("identification bit wrong on tdo");
  a_bypass_zero: assert property (
    @(posedge tck) disable iff (!resetn_i)
    st_r == ST_SH_DR && $past(st_r) == ST_CAP_DR && byp_op |-> !tdo)
    else $error("bypass bit did not capture zero");
  a_line_pullup: assert property (
    @(posedge tck) disable iff (!resetn_i)
    tdo_line == (shift_st ? tdo : 1'b1))
    else $error("released tdo line not high");
endmodule : jtbs_link_chk

// [tb_jtag_tap_boundary_scan.sv]
// Testbench: host end and device end joined over the test link
`timescale 1ns/1ps
module tb_jtag_tap_boundary_scan;
  import jtbs_pkg::*;
  localparam int RST_CYC = 5; // Host stops tck while reset is low
  logic clk_i;
  logic resetn_i;
  logic [NPINS-1:0] core_pud_i;
  logic [NPINS-1:0] core_oe_i;
  logic [NPINS-1:0] core_out_i;
  logic [NPINS-1:0] pad_in_i;
  logic core_ana_ctl_i;
  logic ana_in_i;
  logic [NPINS-1:0] pad_pu_o;
  logic [NPINS-1:0] pad_oe_o;
  logic [NPINS-1:0] pad_out_o;
  logic ana_ctl_o;
  logic device_reset_o;
  logic [IR_W-1:0] instr_o;
  logic start_i;
  logic is_ir_i;
  logic [5:0] len_i;
  logic [31:0] wdata_i;
  logic busy_o;
  logic done_o;
  logic [31:0] rdata_o;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int c;
  integer seed = 54999;
  logic [IR_W-1:0] m_ir;
  logic [BS_LEN-1:0] m_lat;
  logic m_rst;

  // ------------------------------------------------------------------
  // Ends, link and checker
  // ------------------------------------------------------------------
  jtbs_link_if jtbs_link_if_i ();
  jtbs_tap jtbs_tap_i (.clk_i(clk_i), .resetn_i(resetn_i),
    .link(jtbs_link_if_i), .core_pud_i(core_pud_i), .core_oe_i(core_oe_i),
    .core_out_i(core_out_i), .core_ana_ctl_i(core_ana_ctl_i),
    .pad_in_i(pad_in_i), .ana_in_i(ana_in_i), .pad_pu_o(pad_pu_o),
    .pad_oe_o(pad_oe_o), .pad_out_o(pad_out_o), .ana_ctl_o(ana_ctl_o),
    .device_reset_o(device_reset_o), .instr_o(instr_o));
  jtbs_host jtbs_host_i (.clk_i(clk_i), .resetn_i(resetn_i),
    .link(jtbs_link_if_i), .start_i(start_i), .is_ir_i(is_ir_i),
    .len_i(len_i), .wdata_i(wdata_i), .busy_o(busy_o), .done_o(done_o),
    .rdata_o(rdata_o));
  jtbs_link_chk jtbs_link_chk_i (.tck(jtbs_link_if_i.tck),
    .tms(jtbs_link_if_i.tms), .tdi(jtbs_link_if_i.tdi),
    .tdo(jtbs_link_if_i.tdo), .tdo_oe(jtbs_link_if_i.tdo_oe),
    .tdo_line(jtbs_link_if_i.tdo_line), .resetn_i(resetn_i),
    .instr_o(instr_o));

  // 250 MHz system clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Cut a hang short well above the expected run length
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      test_done();
    end
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic test_done();
    if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic do_reset();
    int n;
    @(negedge clk_i);
    resetn_i = 1'b0;
    repeat (RST_CYC) @(negedge clk_i);
    resetn_i = 1'b1;
    m_ir = OP_IDCODE;
    m_lat = '0;
    m_rst = 1'b0;
    @(negedge clk_i);
    for (n = 0; n < 3000 && busy_o !== 1'b0; n++) @(negedge clk_i);
    chk("instr_o", 32'(OP_IDCODE), 32'(instr_o));
  endtask : do_reset

  // One scan; the model predicts the bits coming back, masking unknowns
  task automatic xfer(input logic ir, input int len, input logic [31:0] w);
    logic [31:0] e;
    logic [31:0] m;
    int n;
    {core_pud_i, core_oe_i, core_out_i, pad_in_i} = 16'($random(seed));
    {core_ana_ctl_i, ana_in_i} = 2'($random(seed));
    e = 32'h0;
    m = (len == 32) ? '1 : (32'h1 << len) - 32'h1;
    if (ir) e = 32'(IR_CAPTURE);
    else if (m_ir == OP_IDCODE) e = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
    else if (m_ir inside {OP_EXTEST, OP_SAMPLE}) begin
      m = 32'h1 << CELL_ANA_IN;
      e[CELL_ANA_IN] = ana_in_i;
      for (n = 0; n < NPINS; n++) begin
        m[4*n+CELL_ID] = 1'b1;
        e[4*n+CELL_ID] = pad_in_i[n];
      end
    end else if (m_ir == OP_DEVRST) e[0] = m_rst;
    else e = {w[30:0], 1'b0};
    for (n = 0; n < 3000 && busy_o !== 1'b0; n++) @(negedge clk_i);
    start_i = 1'b1;
    is_ir_i = ir;
    len_i = 6'(len);
    wdata_i = w;
    @(negedge clk_i);
    start_i = 1'b0;
    chk("busy_o", 32'h1, 32'(busy_o));
    for (n = 0; n < 3000 && done_o !== 1'b1; n++) @(negedge clk_i);
    chk("done_o", 32'h1, 32'(done_o));
    chk("rdata_o", e & m, rdata_o & m);
    if (ir) m_ir = w[IR_W-1:0];
    else if (m_ir inside {OP_EXTEST, OP_SAMPLE}) m_lat = w[BS_LEN-1:0];
    else if (m_ir == OP_DEVRST) m_rst = w[0];
    if (ir) chk("instr_o", 32'(m_ir), 32'(instr_o));
  endtask : xfer

  task automatic chk_pads();
    logic [NPINS-1:0] e_oe;
    logic [NPINS-1:0] e_out;
    logic [NPINS-1:0] e_pu;
    logic [NPINS-1:0] m_pu;
    logic e_ana;
    int p;
    e_oe = core_oe_i;
    e_out = core_out_i;
    e_pu = '0;
    m_pu = '0; // Pull-up in core mode is not predicted
    e_ana = core_ana_ctl_i;
    if (m_ir == OP_EXTEST) begin
      m_pu = '1;
      for (p = 0; p < NPINS; p++) begin
        e_pu[p] = ~m_lat[4*p+CELL_PUD];
        e_oe[p] = m_lat[4*p+CELL_OC];
        e_out[p] = m_lat[4*p+CELL_OD];
      end
      e_ana = m_lat[CELL_ANA_CTL];
    end else if (m_rst) begin
      e_oe = '0;
      m_pu = '1;
    end
    chk("pad_oe_o", 32'(e_oe), 32'(pad_oe_o));
    if (!m_rst) chk("pad_out_o", 32'(e_out), 32'(pad_out_o));
    chk("pad_pu_o", 32'(e_pu & m_pu), 32'(pad_pu_o & m_pu));
    chk("ana_ctl_o", 32'(e_ana), 32'(ana_ctl_o));
  endtask : chk_pads

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    resetn_i = 1'b1;
    start_i = 1'b0;
    is_ir_i = 1'b0;
    len_i = 6'h0;
    wdata_i = 32'h0;
    {core_pud_i, core_oe_i, core_out_i, pad_in_i} = 16'h0;
    core_ana_ctl_i = 1'b0;
    ana_in_i = 1'b0;
    do_reset();
    xfer(1'b0, 32, 32'($random(seed)));
    xfer(1'b1, 4, 32'(OP_SAMPLE));
    xfer(1'b0, BS_LEN, 32'($random(seed)));
    chk_pads();
    xfer(1'b1, 4, 32'(OP_EXTEST));
    chk_pads();
    xfer(1'b0, BS_LEN, 32'($random(seed)));
    chk_pads();
    xfer(1'b0, BS_LEN, 32'($random(seed)));
    chk_pads();
    for (c = 3; c < 16; c++) begin
      if (c != 12) xfer(1'b1, 4, 32'(c));
      if (c != 12) xfer(1'b0, 2, 32'($random(seed)));
    end
    chk_pads();
    xfer(1'b1, 4, 32'(OP_DEVRST));
    xfer(1'b0, 1, 32'h1);
    repeat (4) @(negedge clk_i);
    chk("device_reset_o", 32'h1, 32'(device_reset_o));
    chk("instr_o", 32'(OP_DEVRST), 32'(instr_o));
    chk_pads();
    xfer(1'b0, 1, 32'h0);
    repeat (4) @(negedge clk_i);
    chk("device_reset_o", 32'h0, 32'(device_reset_o));
    do_reset();
    xfer(1'b0, 32, 32'($random(seed)));
    test_done();
  end
endmodule : tb_jtag_tap_boundary_scan
